// ==== core/rsi_top.sv ====
`include "rsi_cfg.svh"

module rsi_top
  import rsi_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `RSI_DEV_ADDR_DEFAULT // arbitrary bus address
) (
  input wire logic clk_i,                      // system clock, 20 MHz
  input wire logic reset_i,                    // synchronous reset, high
  input wire logic scl_i,                      // serial clock pin level
  input wire logic sda_i,                      // serial data pin level
  output logic sda_o,                          // serial data drive value
  output logic sda_oe_o,                       // serial data pull low
  input wire logic linreg1_enabled_i,          // regulator 1 on
  input wire logic linreg1_output_invalid_i,   // regulator 1 output bad
  input wire logic linreg1_current_limited_i,  // regulator 1 limiting
  input wire logic linreg0_enabled_i,          // regulator 0 on
  input wire logic linreg0_output_invalid_i,   // regulator 0 output bad
  input wire logic linreg0_current_limited_i,  // regulator 0 limiting
  input wire logic power_ok_live_i,            // power-good level
  input wire logic sync_clk_live_i,            // external clock invalid level
  input wire logic thermal_warning_live_i,     // die warning level
  input wire logic load_meas_ready_i,          // measurement done request
  input wire logic reg_reset_event_i,          // register reset request
  input wire logic otp_reset_reg_mask_i,       // stored mask value
  output logic power_ok_live_o,                // power-good live status
  output logic sync_clk_live_o,                // clock invalid live status
  output logic thermal_warning_live_o,         // thermal warning live status
  output logic power_ok_irq_flag_o,            // power-good flag set pulse
  output logic sync_clk_irq_flag_o,            // clock flag set pulse
  output logic thermal_warning_irq_flag_o,     // thermal flag set pulse
  output logic load_meas_ready_irq_flag_o,     // measurement flag set pulse
  output logic reg_reset_irq_flag_o,           // register reset flag set pulse
  output logic irq_o                           // interrupt pulse
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [`RSI_LN_COUNT-1:0] raw;
  logic [`RSI_LN_COUNT-1:0] sy;

  assign raw[`RSI_LN_SCL] = scl_i;
  assign raw[`RSI_LN_SDA] = sda_i;
  assign raw[`RSI_LN_LR1_EN] = linreg1_enabled_i;
  assign raw[`RSI_LN_LR1_INV] = linreg1_output_invalid_i;
  assign raw[`RSI_LN_LR1_ILIM] = linreg1_current_limited_i;
  assign raw[`RSI_LN_LR0_EN] = linreg0_enabled_i;
  assign raw[`RSI_LN_LR0_INV] = linreg0_output_invalid_i;
  assign raw[`RSI_LN_LR0_ILIM] = linreg0_current_limited_i;
  assign raw[`RSI_LN_EV_BASE + `RSI_EV_POWER_OK] = power_ok_live_i;
  assign raw[`RSI_LN_EV_BASE + `RSI_EV_SYNC_CLK] = sync_clk_live_i;
  assign raw[`RSI_LN_EV_BASE + `RSI_EV_THERMAL] = thermal_warning_live_i;
  assign raw[`RSI_LN_EV_BASE + `RSI_EV_LOAD_MEAS] = load_meas_ready_i;
  assign raw[`RSI_LN_EV_BASE + `RSI_EV_REG_RESET] = reg_reset_event_i;
  assign raw[`RSI_LN_OTP] = otp_reset_reg_mask_i;

  rsi_sync #(
    .W(`RSI_LN_COUNT)
  ) u_sync (
    .clk_i(clk_i),
    .d_i(raw),
    .q_o(sy)
  );

  logic scl_s;
  logic sda_s;
  logic [`RSI_EV_COUNT-1:0] ev_level;

  assign scl_s = sy[`RSI_LN_SCL];
  assign sda_s = sy[`RSI_LN_SDA];
  assign ev_level = sy[`RSI_LN_EV_BASE +: `RSI_EV_COUNT];

  // ----------------------------------------
  // regulator status byte
  // ----------------------------------------
  logic [7:0] linreg_stat;

  always_comb
  begin
    // reserved bits 5 and 1 read as zero
    linreg_stat = 8'h00;
    linreg_stat[`RSI_ST_LR1_EN] = sy[`RSI_LN_LR1_EN]; // RQ1
    linreg_stat[`RSI_ST_LR0_EN] = sy[`RSI_LN_LR0_EN]; // RQ1
    // raw, unfiltered: the host sees glitches as they happen
    linreg_stat[`RSI_ST_LR1_INV] = sy[`RSI_LN_LR1_INV]; // RQ2
    linreg_stat[`RSI_ST_LR0_INV] = sy[`RSI_LN_LR0_INV]; // RQ2
    linreg_stat[`RSI_ST_LR1_ILIM] = sy[`RSI_LN_LR1_ILIM]; // RQ3
    linreg_stat[`RSI_ST_LR0_ILIM] = sy[`RSI_LN_LR0_ILIM]; // RQ3
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  rsi_top_s r;
  rsi_top_s n;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0] rdata;

  always_comb
  begin
    unique case (r.ptr)
      `RSI_REG_LINREG_STAT:
      begin
        rdata = linreg_stat;
      end
      `RSI_REG_MASK_A:
      begin
        rdata = r.mask_a;
      end
      `RSI_REG_MASK_B:
      begin
        rdata = r.mask_b;
      end
      default:
      begin
        rdata = `RSI_READ_UNMAPPED;
      end
    endcase
  end

  // ----------------------------------------
  // serial slave and register file
  // ----------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_done;

  always_comb
  begin
    n = r;
    n.scl_d = scl_s;
    n.sda_d = sda_s;
    scl_rise = scl_s & ~r.scl_d;
    scl_fall = ~scl_s & r.scl_d;
    // data moving while the clock is high marks frame boundaries
    bus_start = r.scl_d & scl_s & r.sda_d & ~sda_s;
    bus_stop = r.scl_d & scl_s & ~r.sda_d & sda_s;
    byte_done = (r.cnt == `RSI_BITS_PER_BYTE);
    if (bus_start)
    begin
      n.state = RSI_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      n.state = RSI_IDLE;
      n.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      unique case (r.state)
        RSI_ADDR, RSI_REG, RSI_WDATA:
        begin
          n.shift = {r.shift[6:0], sda_s};
          n.cnt = r.cnt + 4'h1;
        end
        RSI_RDATA:
        begin
          n.cnt = r.cnt + 4'h1;
        end
        RSI_RDATA_ACK:
        begin
          // a released line is a refusal: stop sending until the next frame
          if (sda_s)
          begin
            n.state = RSI_WAIT;
          end
          else
          begin
            n.ptr = r.ptr + 8'h01;
          end
        end
        RSI_IDLE, RSI_ADDR_ACK, RSI_REG_ACK, RSI_WDATA_ACK, RSI_WAIT:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      unique case (r.state)
        RSI_ADDR:
        begin
          if (byte_done)
          begin
            if (r.shift[7:1] == DEV_ADDR)
            begin
              n.rw = r.shift[0];
              n.sda_oe = 1'b1;
              n.state = RSI_ADDR_ACK;
            end
            else
            begin
              n.state = RSI_WAIT;
            end
          end
        end
        RSI_REG:
        begin
          if (byte_done)
          begin
            n.ptr = r.shift;
            n.sda_oe = 1'b1;
            n.state = RSI_REG_ACK;
          end
        end
        RSI_WDATA:
        begin
          if (byte_done)
          begin
            unique case (r.ptr)
              `RSI_REG_MASK_A:
              begin
                // reserved bits are plain storage, no effect elsewhere
                n.mask_a = r.shift; // RQ5
              end
              `RSI_REG_MASK_B:
              begin
                n.mask_b = r.shift; // RQ11
              end
              default:
              begin
                // status and unmapped addresses drop the byte, still acked
              end
            endcase
            n.ptr = r.ptr + 8'h01;
            n.sda_oe = 1'b1;
            n.state = RSI_WDATA_ACK;
          end
        end
        RSI_ADDR_ACK:
        begin
          if (r.rw)
          begin
            n.shift = rdata;
            n.sda_oe = ~rdata[7];
            n.cnt = 4'h0;
            n.state = RSI_RDATA;
          end
          else
          begin
            n.sda_oe = 1'b0;
            n.cnt = 4'h0;
            n.state = RSI_REG;
          end
        end
        RSI_REG_ACK, RSI_WDATA_ACK:
        begin
          n.sda_oe = 1'b0;
          n.cnt = 4'h0;
          n.state = RSI_WDATA;
        end
        RSI_RDATA:
        begin
          if (byte_done)
          begin
            n.sda_oe = 1'b0;
            n.state = RSI_RDATA_ACK;
          end
          else
          begin
            n.shift = {r.shift[6:0], 1'b0};
            n.sda_oe = ~r.shift[6];
          end
        end
        RSI_RDATA_ACK:
        begin
          // pointer already advanced on the acknowledging edge
          n.shift = rdata;
          n.sda_oe = ~rdata[7];
          n.cnt = 4'h0;
          n.state = RSI_RDATA;
        end
        RSI_IDLE, RSI_WAIT:
        begin
        end
      endcase
    end
    if (reset_i)
    begin
      n = '0;
      n.state = RSI_IDLE;
      // bus idles high; avoids a false clock rise right after reset
      n.scl_d = 1'b1;
      n.sda_d = 1'b1;
      n.mask_a = `RSI_MASK_A_RESET; // RQ4 RQ6 RQ7 RQ8
      n.mask_b = `RSI_MASK_B_RESET; // RQ9 RQ11
      // host writes to this bit only last until the next reset
      n.mask_b[`RSI_MB_REG_RESET] = sy[`RSI_LN_OTP]; // RQ10
    end
  end

  always_ff @(posedge clk_i)
  begin
    r <= n;
  end

  // ----------------------------------------
  // event gating
  // ----------------------------------------
  rsi_evt_if evt ();

  assign evt.level = ev_level;
  assign evt.mask[`RSI_EV_POWER_OK] = r.mask_a[`RSI_MA_POWER_OK]; // RQ4
  assign evt.mask[`RSI_EV_SYNC_CLK] = r.mask_a[`RSI_MA_SYNC_CLK]; // RQ6
  assign evt.mask[`RSI_EV_THERMAL] = r.mask_a[`RSI_MA_THERMAL]; // RQ7
  assign evt.mask[`RSI_EV_LOAD_MEAS] = r.mask_a[`RSI_MA_LOAD_MEAS]; // RQ8
  assign evt.mask[`RSI_EV_REG_RESET] = r.mask_b[`RSI_MB_REG_RESET]; // RQ9

  rsi_evt_gate u_evt_gate (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .evt(evt)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open-drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = r.sda_oe;
  // live levels bypass the masks entirely
  assign power_ok_live_o = ev_level[`RSI_EV_POWER_OK]; // RQ5
  assign sync_clk_live_o = ev_level[`RSI_EV_SYNC_CLK]; // RQ5
  assign thermal_warning_live_o = ev_level[`RSI_EV_THERMAL]; // RQ5
  assign power_ok_irq_flag_o = evt.flag[`RSI_EV_POWER_OK];
  assign sync_clk_irq_flag_o = evt.flag[`RSI_EV_SYNC_CLK];
  assign thermal_warning_irq_flag_o = evt.flag[`RSI_EV_THERMAL];
  assign load_meas_ready_irq_flag_o = evt.flag[`RSI_EV_LOAD_MEAS];
  assign reg_reset_irq_flag_o = evt.flag[`RSI_EV_REG_RESET];
  assign irq_o = evt.irq;
endmodule : rsi_top

// ==== core/rsi_cfg.svh ====
`ifndef RSI_CFG_SVH
`define RSI_CFG_SVH
// Behaviour
// RQ1: status bits 7 and 3 read 1 while regulator 1 or 0 is enabled.
// RQ2: status bits 6 and 2 read 1 while regulator output is invalid, unfiltered.
// RQ3: status bits 4 and 0 read 1 while regulator current limit is active.
// RQ4: power-good mask at mask_a bit 7 resets to 1; 1 suppresses interrupt.
// RQ5: masks only gate interrupts; live status bits stay untouched by masks.
// RQ6: sync clock mask at mask_a bit 4 resets to 1; 1 blocks interrupt.
// RQ7: thermal warning mask at mask_a bit 2 resets to 0; 1 blocks.
// RQ8: load measurement ready mask at mask_a bit 0 resets to 0; 1 suppresses.
// RQ9: register-reset mask at mask_b bit 0 resets to 1; 1 suppresses.
// RQ10: register-reset mask reloads from one-time memory at every reset.
// RQ11: mask_b bits 7:1 are reserved, read/write, reset to zero.
// RQ12: flag and interrupt raised only on event with its mask bit 0.

// ----------------------------------------
// register map
// ----------------------------------------
`define RSI_REG_LINREG_STAT 8'h1F
`define RSI_REG_MASK_A 8'h20
`define RSI_REG_MASK_B 8'h21
`define RSI_MASK_A_RESET 8'h90
`define RSI_MASK_B_RESET 8'h01
`define RSI_READ_UNMAPPED 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define RSI_ST_LR1_EN 7
`define RSI_ST_LR1_INV 6
`define RSI_ST_LR1_ILIM 4
`define RSI_ST_LR0_EN 3
`define RSI_ST_LR0_INV 2
`define RSI_ST_LR0_ILIM 0
`define RSI_MA_POWER_OK 7
`define RSI_MA_SYNC_CLK 4
`define RSI_MA_THERMAL 2
`define RSI_MA_LOAD_MEAS 0
`define RSI_MB_REG_RESET 0

// ----------------------------------------
// event indices and synchroniser lanes
// ----------------------------------------
`define RSI_EV_POWER_OK 0
`define RSI_EV_SYNC_CLK 1
`define RSI_EV_THERMAL 2
`define RSI_EV_LOAD_MEAS 3
`define RSI_EV_REG_RESET 4
`define RSI_EV_COUNT 5
`define RSI_LN_SCL 0
`define RSI_LN_SDA 1
`define RSI_LN_LR1_EN 2
`define RSI_LN_LR1_INV 3
`define RSI_LN_LR1_ILIM 4
`define RSI_LN_LR0_EN 5
`define RSI_LN_LR0_INV 6
`define RSI_LN_LR0_ILIM 7
`define RSI_LN_EV_BASE 8
`define RSI_LN_OTP 13
`define RSI_LN_COUNT 14

// ----------------------------------------
// serial bus
// ----------------------------------------
`define RSI_BITS_PER_BYTE 4'h8
`define RSI_DEV_ADDR_DEFAULT 7'h5A
`endif

// ==== core/rsi_pkg.sv ====
package rsi_pkg;
  typedef enum logic [3:0] {
    RSI_IDLE = 4'b0000,
    RSI_ADDR = 4'b0001,
    RSI_ADDR_ACK = 4'b0010,
    RSI_REG = 4'b0011,
    RSI_REG_ACK = 4'b0100,
    RSI_WDATA = 4'b0101,
    RSI_WDATA_ACK = 4'b0110,
    RSI_RDATA = 4'b0111,
    RSI_RDATA_ACK = 4'b1000,
    RSI_WAIT = 4'b1001
  } rsi_i2c_e;

  typedef struct packed {
    rsi_i2c_e state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
    logic [7:0] mask_a;
    logic [7:0] mask_b;
  } rsi_top_s;

  typedef struct packed {
    logic [4:0] prev;
    logic [4:0] flag;
    logic irq;
  } rsi_evt_s;
endpackage : rsi_pkg

// ==== core/rsi_evt_if.sv ====
interface rsi_evt_if;
  logic [4:0] level;
  logic [4:0] mask;
  logic [4:0] flag;
  logic irq;
  modport core (output level, output mask, input flag, input irq);
  modport gate (input level, input mask, output flag, output irq);
endinterface : rsi_evt_if

// ==== core/rsi_sync.sv ====
module rsi_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,          // system clock
  input wire logic [W-1:0] d_i,    // asynchronous inputs
  output logic [W-1:0] q_o         // synchronised copy
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rsi_sync_s;

  rsi_sync_s r;
  rsi_sync_s n;

  // data path only: no reset, reset is held long enough to flush it
  always_comb
  begin
    n = r;
    n.meta = d_i;
    n.stable = r.meta;
  end

  always_ff @(posedge clk_i)
  begin
    r <= n;
  end

  assign q_o = r.stable;
endmodule : rsi_sync

// ==== core/rsi_evt_gate.sv ====
module rsi_evt_gate
  import rsi_pkg::*;
(
  input wire logic clk_i,    // system clock
  input wire logic reset_i,  // synchronous reset, high
  rsi_evt_if.gate evt        // event levels, masks, flags
);
  rsi_evt_s r;
  rsi_evt_s n;
  logic [4:0] rise;

  always_comb
  begin
    n = r;
    rise = evt.level & ~r.prev;
    n.prev = evt.level;
    // a set mask only drops the pulse, the level itself passes on untouched
    n.flag = rise & ~evt.mask; // RQ12 RQ5
    n.irq = |(rise & ~evt.mask); // RQ12
    if (reset_i)
    begin
      n = '0;
      // no event on the first level seen after reset
      n.prev = evt.level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    r <= n;
  end

  assign evt.flag = r.flag;
  assign evt.irq = r.irq;
endmodule : rsi_evt_gate

// ==== tb/rsi_top_chk.sv ====
module rsi_top_chk (
  input wire logic clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic scl_i, // serial clock
  input wire logic sda_oe_o, // data pull low
  input wire logic power_ok_live_i, // level in
  input wire logic sync_clk_live_i, // level in
  input wire logic thermal_warning_live_i, // level in
  input wire logic load_meas_ready_i, // event in
  input wire logic reg_reset_event_i, // event in
  input wire logic power_ok_live_o, // live out
  input wire logic sync_clk_live_o, // live out
  input wire logic thermal_warning_live_o, // live out
  input wire logic power_ok_irq_flag_o, // flag
  input wire logic sync_clk_irq_flag_o, // flag
  input wire logic thermal_warning_irq_flag_o, // flag
  input wire logic load_meas_ready_irq_flag_o, // flag
  input wire logic reg_reset_irq_flag_o, // flag
  input wire logic irq_o // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  a_pok_live_follow: assert property (power_ok_live_o == $past(power_ok_live_i, 2))
    else $error("power ok live copy wrong");
  a_sync_live_follow: assert property (sync_clk_live_o == $past(sync_clk_live_i, 2))
    else $error("sync clock live copy wrong");
  a_therm_live_follow: assert property (thermal_warning_live_o == $past(thermal_warning_live_i, 2))
    else $error("thermal live copy wrong");
  a_irq_or_flags: assert property (irq_o == |{power_ok_irq_flag_o, sync_clk_irq_flag_o,
    thermal_warning_irq_flag_o, load_meas_ready_irq_flag_o, reg_reset_irq_flag_o}) else $error("irq not or of flags");
  a_pok_flag_pulse: assert property (power_ok_irq_flag_o |=> !power_ok_irq_flag_o)
    else $error("power ok flag too long");
  a_therm_flag_edge: assert property (thermal_warning_irq_flag_o |->
    $past(thermal_warning_live_i, 3) && !$past(thermal_warning_live_i, 4)) else $error("thermal flag without edge");
  a_meas_flag_cause: assert property ($rose(load_meas_ready_irq_flag_o) |-> $past(load_meas_ready_i, 3))
    else $error("meas flag without event");
  a_rst_flag_edge: assert property (reg_reset_irq_flag_o |-> $past(reg_reset_event_i, 3) && !$past(reg_reset_event_i, 4))
    else $error("reset flag without edge");
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data changed with clock high");
  c_irq: cover property (irq_o);
  c_therm: cover property (thermal_warning_irq_flag_o);
  c_ack: cover property ($rose(sda_oe_o));
endmodule : rsi_top_chk

bind rsi_top rsi_top_chk rsi_top_chk_inst (.*);

// ==== tb/rsi_host.sv ====
module rsi_host (
  input wire logic clk_i, // paces the bus
  input wire logic sda_i, // resolved data line
  output logic scl_o, // serial clock
  output logic low_o // pulls data low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl_o = 1'b1;
    low_o = 1'b0;
  end
  // one third of a bit, 6 clocks, above the 4-clock minimum
  task q;
    repeat (6) @(negedge clk_i);
  endtask : q
  task start;
    low_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    low_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask : start
  task stop;
    low_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    low_o = 1'b0;
    q();
  endtask : stop
  // nine bits msb first, last one the acknowledge slot
  task xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      low_o = !d[i];
      q();
      scl_o = 1'b1;
      q();
      r[i] = sda_i;
      scl_o = 1'b0;
      q();
    end
  endtask : xfer
endmodule : rsi_host

// ==== tb/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, reset_i, scl_i, sda_i, sda_o, sda_oe_o, host_low, irq_o;
  logic linreg1_enabled_i, linreg1_output_invalid_i, linreg1_current_limited_i;
  logic linreg0_enabled_i, linreg0_output_invalid_i, linreg0_current_limited_i;
  logic power_ok_live_i, sync_clk_live_i, thermal_warning_live_i, load_meas_ready_i, reg_reset_event_i;
  logic otp_reset_reg_mask_i, power_ok_live_o, sync_clk_live_o, thermal_warning_live_o;
  logic power_ok_irq_flag_o, sync_clk_irq_flag_o, thermal_warning_irq_flag_o;
  logic load_meas_ready_irq_flag_o, reg_reset_irq_flag_o;
  logic [4:0] seen;
  logic irq_seen;
  logic [8:0] r;
  logic [7:0] d;
  logic [5:0] p;
  int mismatches, n_tests;
  rsi_top rsi_top_inst (.*);
  rsi_host rsi_host_inst (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .low_o(host_low));
  // open drain with pull-up
  assign sda_i = ~(sda_oe_o | host_low);
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) seen <= seen | {reg_reset_irq_flag_o, load_meas_ready_irq_flag_o,
    thermal_warning_irq_flag_o, sync_clk_irq_flag_o, power_ok_irq_flag_o};
  always @(posedge clk_i) irq_seen <= irq_seen | irq_o;
  task chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // synchronisers need two edges to flush; a third lets reset load their values
  task do_reset;
    reset_i = 1'b1;
    repeat (3) @(negedge clk_i);
    reset_i = 1'b0;
  endtask : do_reset
  task wr(input logic [7:0] a, input logic [7:0] v);
    rsi_host_inst.start();
    rsi_host_inst.xfer({7'h5A, 2'b01}, r);
    chk({sda_o, r[0]}, 2'b00);
    rsi_host_inst.xfer({a, 1'b1}, r);
    rsi_host_inst.xfer({v, 1'b1}, r);
    rsi_host_inst.stop();
  endtask : wr
  task rd(input logic [7:0] a);
    rsi_host_inst.start();
    rsi_host_inst.xfer({7'h5A, 2'b01}, r);
    rsi_host_inst.xfer({a, 1'b1}, r);
    rsi_host_inst.start();
    rsi_host_inst.xfer({7'h5A, 2'b11}, r);
    rsi_host_inst.xfer(9'h1FF, r);
    d = r[8:1];
    rsi_host_inst.stop();
  endtask : rd
  task fire(input logic [4:0] e);
    seen = 5'h00;
    irq_seen = 1'b0;
    {reg_reset_event_i, load_meas_ready_i, thermal_warning_live_i, sync_clk_live_i, power_ok_live_i} = 5'h1F;
    repeat (10) @(negedge clk_i);
    chk({thermal_warning_live_o, sync_clk_live_o, power_ok_live_o}, 3'h7);
    {reg_reset_event_i, load_meas_ready_i, thermal_warning_live_i, sync_clk_live_i, power_ok_live_i} = 5'h00;
    repeat (10) @(negedge clk_i);
    chk(seen, e);
    chk(irq_seen, |e);
  endtask : fire
  task t_defaults;
    rd(8'h20);
    chk(d, 8'h90);
    rd(8'h21);
    chk(d, 8'h01);
    rd(8'h30);
    chk(d, 8'h00);
    $display("t_defaults done");
  endtask : t_defaults
  task t_status;
    for (int i = 0; i < 8; i++)
    begin
      p = (i == 7) ? 6'h3F : 6'h01 << i;
      {linreg1_enabled_i, linreg1_output_invalid_i, linreg1_current_limited_i} = p[5:3];
      {linreg0_enabled_i, linreg0_output_invalid_i, linreg0_current_limited_i} = p[2:0];
      rd(8'h1F);
      chk(d, {p[5:4], 1'b0, p[3:1], 1'b0, p[0]});
    end
    $display("t_status done");
  endtask : t_status
  task t_masks;
    fire(5'b0_1100);
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h00);
    fire(5'b1_1111);
    wr(8'h20, 8'h6E);
    wr(8'h21, 8'hFF);
    rd(8'h20);
    chk(d, 8'h6E);
    rd(8'h21);
    chk(d, 8'hFF);
    fire(5'b0_1011);
    $display("t_masks done");
  endtask : t_masks
  task t_bus;
    wr(8'h1F, 8'h00);
    rd(8'h1F);
    chk(d, 8'hDD);
    rsi_host_inst.start();
    rsi_host_inst.xfer({7'h5B, 2'b01}, r);
    chk(r[0], 1'b1);
    rsi_host_inst.stop();
    rsi_host_inst.start();
    rsi_host_inst.xfer({7'h5A, 2'b01}, r);
    rsi_host_inst.xfer({8'h20, 1'b1}, r);
    rsi_host_inst.xfer({8'h11, 1'b1}, r);
    rsi_host_inst.xfer({8'h22, 1'b1}, r);
    chk(r[0], 1'b0);
    rsi_host_inst.stop();
    rsi_host_inst.start();
    rsi_host_inst.xfer({7'h5A, 2'b01}, r);
    rsi_host_inst.xfer({8'h20, 1'b1}, r);
    rsi_host_inst.start();
    rsi_host_inst.xfer({7'h5A, 2'b11}, r);
    rsi_host_inst.xfer(9'h1FE, r);
    chk(r[8:1], 8'h11);
    rsi_host_inst.xfer(9'h1FF, r);
    chk(r[8:1], 8'h22);
    rsi_host_inst.stop();
    fire(5'b1_0101);
    $display("t_bus done");
  endtask : t_bus
  task t_otp;
    for (int i = 0; i < 2; i++)
    begin
      otp_reset_reg_mask_i = i[0];
      // reserved bits set too, so their reset to zero is seen
      wr(8'h21, {7'h7F, !i[0]});
      do_reset();
      rd(8'h21);
      chk(d, {7'h00, i[0]});
    end
    $display("t_otp done");
  endtask : t_otp
  initial
  begin
    mismatches = 0;
    n_tests = 0;
    seen = 5'h00;
    irq_seen = 1'b0;
    otp_reset_reg_mask_i = 1'b1;
    {linreg1_enabled_i, linreg1_output_invalid_i, linreg1_current_limited_i} = 3'h0;
    {linreg0_enabled_i, linreg0_output_invalid_i, linreg0_current_limited_i} = 3'h0;
    {reg_reset_event_i, load_meas_ready_i, thermal_warning_live_i, sync_clk_live_i, power_ok_live_i} = 5'h00;
    do_reset();
    t_defaults();
    t_status();
    t_masks();
    t_bus();
    t_otp();
    print_verdict();
  end
  // whole run is about 17000 cycles; limit is 40000
  initial
  begin
    #2_000_000;
    mismatches++;
    print_verdict();
  end
endmodule : tb_top
